// file: pkg/assc_defines.vh
// assc_defines.vh - addresses, field positions and reset values of the
// angle short-stroke configuration block.
// assumes: included by bare name from every design file of the block.
`ifndef ASSC_DEFINES_VH
`define ASSC_DEFINES_VH

// configuration word addresses as seen by the programmer
`define ASSC_ADDR_PREGAIN 6'h3A
`define ASSC_ADDR_GAIN 6'h3B
`define ASSC_ADDR_LIMITS 6'h3C
`define ASSC_ADDR_CLAMPS 6'h3D
`define ASSC_ADDR_LOCK 6'h3E
`define ASSC_ADDR_CUSTOMER 6'h3F
`define ASSC_WORDS 3'h6
`define ASSC_LAST_LOAD 3'h4

// common layout of every word
`define ASSC_ECC_HI 31
`define ASSC_ECC_LO 26
`define ASSC_DATA_HI 25
`define ASSC_WORD_RESET 32'h00000000

// word 0x3A
`define ASSC_PREGAIN_HI 23
`define ASSC_PREGAIN_LO 12
// word 0x3B
`define ASSC_SS_BIT 25
`define ASSC_GAIN_HI 12
`define ASSC_GAIN_LO 0
// word 0x3C
`define ASSC_CE_BIT 25
`define ASSC_WRAP_BIT 24
`define ASSC_MAXIN_HI 23
`define ASSC_MAXIN_LO 12
`define ASSC_MININ_HI 11
`define ASSC_MININ_LO 0
// word 0x3D
`define ASSC_POSTOFF_HI 23
`define ASSC_POSTOFF_LO 12
`define ASSC_HCLAMP_HI 11
`define ASSC_HCLAMP_LO 6
`define ASSC_LCLAMP_HI 5
`define ASSC_LCLAMP_LO 0
// word 0x3E, store write lock
`define ASSC_LOCK_BIT 25

// angle arithmetic: 12-bit full circle, gain of one in 5.8 form
`define ASSC_ANGLE_MAX 12'hFFF
`define ASSC_GAIN_ONE 14'h0100
// one clamp code step, about one percent of full scale
`define ASSC_CLAMP_STEP 12'h02D

`endif

// file: logic/assc_nvm_store.v
// assc_nvm_store.v - six-word configuration store with registered read.
// assumes: the caller never presents an index of six or seven and never
// reads and writes the same word in one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "assc_defines.vh"

module assc_nvm_store (
  input wire clk,
  input wire rst,
  input wire wrEn,
  input wire [2:0] wrIdx,
  input wire [31:0] wrData,
  input wire rdEn,
  input wire [2:0] rdIdx,
  output reg [31:0] rdData
);

  reg [31:0] words_r [0:5];
  integer i;

  // all-zero words carry a valid check code, so reset leaves a clean store
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 6; i = i + 1) begin
        words_r[i] <= `ASSC_WORD_RESET;
      end
    end else if (wrEn && wrIdx < `ASSC_WORDS) begin
      words_r[wrIdx] <= wrData;
    end
  end

  // read data come from a register, one cycle after the request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= `ASSC_WORD_RESET;
    end else if (rdEn && rdIdx < `ASSC_WORDS) begin
      rdData <= words_r[rdIdx];
    end
  end

endmodule // assc_nvm_store

`default_nettype wire

// file: logic/assc_angle_proc.v
// assc_angle_proc.v - configuration store access and angle post-processing.
// assumes: angle samples and access strobes come from logic on clk; the
// manchester-mode and high-voltage levels come from pins and are synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "assc_defines.vh"

// Function
// - every store word is readable, but only while in manchester output mode
// - writes succeed only with lock clear and high-voltage pulses present
// - subtract the pre-gain zero adjust from every angle sample
// - short-stroke bit enables both gain and input limit checks
// - with short stroke, multiply corrected angle by one plus gain field
// - gain field is unsigned fixed point, five integer and eight fraction bits
// - clamp and wrap both off: output wraps at full circle
// - wrap only: output wraps between the low and high clamp limits
// - clamp only: output holds at the first clamp limit reached
// - both on: wrap at full circle, then limit to the clamps
// - flag when corrected angle exceeds maximum input limit, before gain
// - maximum input code all ones disables the maximum check
// - flag when corrected angle is below minimum input limit, before gain
// - minimum input code zero disables the minimum check
// - limit checks run only while short stroke is set
// - add signed post-gain offset after gain and limit checks
// - high clamp applies after gain and offset, one percent steps down
module assc_angle_proc (
  input wire clk,
  input wire rst,
  input wire [11:0] angleIn,
  input wire angleValid,
  input wire manchesterModeIn,
  input wire hvPulseIn,
  input wire [5:0] cfgAddr,
  input wire [31:0] cfgWrData,
  input wire cfgWrReq,
  input wire cfgRdReq,
  output reg [11:0] angleOut,
  output reg angleOutValid,
  output reg diagMaxOut,
  output reg diagMinOut,
  output reg [31:0] cfgRdData,
  output reg cfgRdValid,
  output reg cfgWrDone,
  output reg cfgRefused,
  output reg eccFixed,
  output reg eccDouble,
  output reg cfgReady,
  output reg storeWriteLock
);

  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_FOLD = 3'b100;

  // check bits of a 26-bit data field: five hamming bits plus overall parity
  function [5:0] eccGen;
    input [25:0] d;
    integer pos;
    integer k;
    integer b;
    reg [5:0] c;
    begin
      c = 6'h00;
      k = 0;
      for (pos = 1; pos < 32; pos = pos + 1) begin
        if ((pos & (pos - 1)) != 0) begin
          for (b = 0; b < 5; b = b + 1) begin
            if (pos[b]) c[b] = c[b] ^ d[k];
          end
          k = k + 1;
        end
      end
      c[5] = (^d) ^ (^c[4:0]);
      eccGen = c;
    end
  endfunction

  // returns {double error, corrected, data}; a single flip is repaired
  function [27:0] eccFix;
    input [31:0] w;
    integer pos;
    integer k;
    reg [25:0] d;
    reg [4:0] s;
    reg [5:0] g;
    reg pAll;
    begin
      d = w[`ASSC_DATA_HI:0];
      g = eccGen(d);
      // only the five position bits form the syndrome; bit five is parity
      s = g[4:0] ^ w[`ASSC_ECC_HI-1:`ASSC_ECC_LO];
      pAll = (^w[`ASSC_DATA_HI:0]) ^ (^w[`ASSC_ECC_HI:`ASSC_ECC_LO]);
      k = 0;
      for (pos = 1; pos < 32; pos = pos + 1) begin
        if ((pos & (pos - 1)) != 0) begin
          if (pAll && s == pos[4:0]) d[k] = ~d[k];
          k = k + 1;
        end
      end
      eccFix = {(s != 5'h00) && !pAll, pAll, d};
    end
  endfunction

  // clamp code to angle distance from the end of the scale
  function [11:0] clampOf;
    input [5:0] code;
    begin
      clampOf = {6'h00, code} * `ASSC_CLAMP_STEP;
    end
  endfunction

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] syncA_r;
  reg [1:0] syncB_r;
  reg [1:0] syncC_r;
  reg [1:0] pinLevel_r;
  reg [2:0] loadIdx_r;
  reg loadWait_r;
  reg progWait_r;
  reg [25:0] wordPre_r;
  reg [25:0] wordGain_r;
  reg [25:0] wordLim_r;
  reg [25:0] wordClamp_r;
  reg [11:0] foldV_r;
  reg [12:0] span_r;
  reg [11:0] foldBase_r;
  reg foldDx_r;
  reg foldDn_r;

  wire manchesterMode = pinLevel_r[0];
  wire hvPresent = pinLevel_r[1];
  wire [5:0] addrOff = cfgAddr - `ASSC_ADDR_PREGAIN;
  wire addrOk = (cfgAddr >= `ASSC_ADDR_PREGAIN) && (cfgAddr <= `ASSC_ADDR_CUSTOMER);
  wire [2:0] addrIdx = addrOff[2:0];
  wire inRun = state_r == ST_RUN;
  wire progRead = inRun && cfgRdReq && manchesterMode && addrOk;
  wire progWrite = inRun && cfgWrReq && !cfgRdReq && hvPresent && !storeWriteLock
    && addrOk;
  wire memRdEn = (state_r == ST_LOAD && !loadWait_r) || progRead;
  wire [2:0] memRdIdx = (state_r == ST_LOAD) ? loadIdx_r : addrIdx;
  wire [31:0] memRdData;
  wire [27:0] fixOut = eccFix(memRdData);
  wire [31:0] wrWord = {eccGen(cfgWrData[`ASSC_DATA_HI:0]), cfgWrData[`ASSC_DATA_HI:0]};

  assc_nvm_store store (
    .clk(clk),
    .rst(rst),
    .wrEn(progWrite),
    .wrIdx(addrIdx),
    .wrData(wrWord),
    .rdEn(memRdEn),
    .rdIdx(memRdIdx),
    .rdData(memRdData)
  );

  // three-stage pin synchroniser; a level counts once stages two and three agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_r <= 2'h0;
      syncB_r <= 2'h0;
      syncC_r <= 2'h0;
      pinLevel_r <= 2'h0;
    end else begin
      syncA_r <= {hvPulseIn, manchesterModeIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      pinLevel_r <= (pinLevel_r & (syncB_r ^ syncC_r)) | (syncC_r & ~(syncB_r ^ syncC_r));
    end
  end

  // decoded fields of the working copy
  wire [11:0] preOff = wordPre_r[`ASSC_PREGAIN_HI:`ASSC_PREGAIN_LO];
  wire shortStroke = wordGain_r[`ASSC_SS_BIT];
  wire [12:0] gainField = wordGain_r[`ASSC_GAIN_HI:`ASSC_GAIN_LO];
  wire clampEn = wordLim_r[`ASSC_CE_BIT];
  wire wrapEn = wordLim_r[`ASSC_WRAP_BIT];
  wire [11:0] maxIn = wordLim_r[`ASSC_MAXIN_HI:`ASSC_MAXIN_LO];
  wire [11:0] minIn = wordLim_r[`ASSC_MININ_HI:`ASSC_MININ_LO];
  wire [11:0] postOff = wordClamp_r[`ASSC_POSTOFF_HI:`ASSC_POSTOFF_LO];
  wire [11:0] highLim = `ASSC_ANGLE_MAX - clampOf(wordClamp_r[`ASSC_HCLAMP_HI:`ASSC_HCLAMP_LO]);
  wire [11:0] lowLim = clampOf(wordClamp_r[`ASSC_LCLAMP_HI:`ASSC_LCLAMP_LO]);

  // processing chain, one combinational pass in the order listed
  reg [11:0] corr;
  reg [13:0] gainFull;
  reg [25:0] prod;
  reg [17:0] scaled;
  reg [19:0] postVal;
  reg [11:0] wrapped;
  reg [11:0] result;
  reg needFold;
  reg diagMax;
  reg diagMin;
  always @* begin
    corr = angleIn - preOff;
    diagMax = shortStroke && (corr > maxIn);
    diagMin = shortStroke && (corr < minIn);
    gainFull = `ASSC_GAIN_ONE + {1'b0, gainField};
    prod = corr * gainFull;
    scaled = shortStroke ? prod[25:8] : {6'h00, corr};
    postVal = {2'b00, scaled} + {{8{postOff[11]}}, postOff};
    wrapped = postVal[11:0];
    needFold = 1'b0;
    case ({clampEn, wrapEn})
      2'b00: result = wrapped;
      2'b01: begin
        result = wrapped - lowLim;
        needFold = highLim >= lowLim;
        if (!needFold) result = lowLim;
      end
      2'b10: begin
        // the unwrapped value tells which limit was reached first
        if (postVal[19]) result = lowLim;
        else if (postVal > {8'h00, highLim}) result = highLim;
        else if (wrapped < lowLim) result = lowLim;
        else result = wrapped;
      end
      2'b11: begin
        if (wrapped > highLim) result = highLim;
        else if (wrapped < lowLim) result = lowLim;
        else result = wrapped;
      end
      default: result = wrapped;
    endcase
  end

  // state sequencing: load the working copy, run, fold for clamp wrapping
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: begin
        if (loadWait_r && loadIdx_r == `ASSC_LAST_LOAD) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (progWrite) state_nxt = ST_LOAD;
        else if (angleValid && needFold) state_nxt = ST_FOLD;
      end
      ST_FOLD: begin
        if ({1'b0, foldV_r} < span_r) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) state_r <= ST_LOAD;
    else state_r <= state_nxt;
  end

  // working copy refresh; every load starts over after a write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      loadIdx_r <= 3'h0;
      loadWait_r <= 1'b0;
      wordPre_r <= 26'h0000000;
      wordGain_r <= 26'h0000000;
      wordLim_r <= 26'h0000000;
      wordClamp_r <= 26'h0000000;
      storeWriteLock <= 1'b0;
    end else if (state_r == ST_LOAD) begin
      loadWait_r <= !loadWait_r;
      if (loadWait_r) begin
        loadIdx_r <= (loadIdx_r == `ASSC_LAST_LOAD) ? 3'h0 : loadIdx_r + 3'h1;
        case (loadIdx_r)
          3'h0: wordPre_r <= fixOut[25:0];
          3'h1: wordGain_r <= fixOut[25:0];
          3'h2: wordLim_r <= fixOut[25:0];
          3'h3: wordClamp_r <= fixOut[25:0];
          3'h4: storeWriteLock <= fixOut[`ASSC_LOCK_BIT];
          default: loadIdx_r <= 3'h0;
        endcase
      end
    end else begin
      loadIdx_r <= 3'h0;
      loadWait_r <= 1'b0;
    end
  end

  // programmer access answers; reserved bits are stored as written
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      progWait_r <= 1'b0;
      cfgRdData <= `ASSC_WORD_RESET;
      cfgRdValid <= 1'b0;
      cfgWrDone <= 1'b0;
      cfgRefused <= 1'b0;
      eccFixed <= 1'b0;
      eccDouble <= 1'b0;
      cfgReady <= 1'b0;
    end else begin
      progWait_r <= progRead;
      cfgRdValid <= progWait_r;
      cfgWrDone <= progWrite;
      cfgRefused <= (cfgRdReq && !progRead) || (cfgWrReq && !progWrite);
      cfgReady <= state_nxt == ST_RUN;
      if (progWait_r) begin
        cfgRdData <= {memRdData[`ASSC_ECC_HI:`ASSC_ECC_LO], fixOut[25:0]};
      end
      // check flags follow every store read, both load and programmer
      if (progWait_r || (state_r == ST_LOAD && loadWait_r)) begin
        eccFixed <= fixOut[26];
        eccDouble <= fixOut[27];
      end
    end
  end

  // sample path; a sample arriving while folding or loading is dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      angleOut <= 12'h000;
      angleOutValid <= 1'b0;
      diagMaxOut <= 1'b0;
      diagMinOut <= 1'b0;
      foldV_r <= 12'h000;
      span_r <= 13'h0001;
      foldBase_r <= 12'h000;
      foldDx_r <= 1'b0;
      foldDn_r <= 1'b0;
    end else begin
      angleOutValid <= 1'b0;
      if (inRun && angleValid && !progWrite) begin
        if (needFold) begin
          // diagnostics wait for the folded angle so both appear together
          foldV_r <= result;
          foldBase_r <= lowLim;
          span_r <= {1'b0, highLim} - {1'b0, lowLim} + 13'h0001;
          foldDx_r <= diagMax;
          foldDn_r <= diagMin;
        end else begin
          angleOut <= result;
          angleOutValid <= 1'b1;
          diagMaxOut <= diagMax;
          diagMinOut <= diagMin;
        end
      end else if (state_r == ST_FOLD) begin
        // repeated subtraction trades latency for no divider
        if ({1'b0, foldV_r} >= span_r) begin
          foldV_r <= foldV_r - span_r[11:0];
        end else begin
          angleOut <= foldBase_r + foldV_r;
          angleOutValid <= 1'b1;
          diagMaxOut <= foldDx_r;
          diagMinOut <= foldDn_r;
        end
      end
    end
  end

endmodule // assc_angle_proc

`default_nettype wire

// file: test/assc_props.sv
// assc_props.sv - port assertions for the angle configuration block.
// assumes: bound to assc_angle_proc; one clock, async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module assc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] cfgAddr,
  input wire logic cfgWrReq,
  input wire logic cfgRdReq,
  input wire logic [11:0] angleOut,
  input wire logic angleOutValid,
  input wire logic diagMaxOut,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  input wire logic cfgWrDone,
  input wire logic cfgRefused,
  input wire logic eccFixed,
  input wire logic eccDouble,
  input wire logic cfgReady,
  input wire logic storeWriteLock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a lone read is refused one edge on, or answered the edge after
  sequence rdTaken;
    cfgRdReq && cfgReady && !cfgWrReq;
  endsequence
  sequence rdAnswer;
    ##1 ((cfgRefused ##1 !cfgRdValid) or (!cfgRefused ##1 cfgRdValid));
  endsequence
  a_rd_answer: assert property (rdTaken |-> rdAnswer)
    else $error("read answer wrong");
  a_rd_badaddr: assert property (cfgRdReq && cfgReady && cfgAddr < 6'h3A |=> cfgRefused)
    else $error("unmapped read not refused");
  a_rd_cause: assert property (cfgRdValid |-> $past(cfgRdReq, 2))
    else $error("read data without request");
  a_rd_hold: assert property (!cfgRdValid |-> $stable(cfgRdData))
    else $error("read data moved");
  a_wr_cause: assert property (cfgWrDone |-> $past(cfgWrReq) && !$past(storeWriteLock))
    else $error("write done without cause");
  a_wr_locked: assert property (cfgWrReq && storeWriteLock |=> cfgRefused && !cfgWrDone)
    else $error("locked write accepted");
  // the working copy reloads after a write, so requests stop for a while
  a_wr_reload: assert property (cfgWrDone |-> !cfgReady [*3])
    else $error("no reload after write");
  a_lock_load: assert property ($changed(storeWriteLock) |-> !$past(cfgReady))
    else $error("lock moved outside load");
  a_out_hold: assert property (!angleOutValid |-> $stable(angleOut) && $stable(diagMaxOut))
    else $error("angle output moved");
  a_ecc_excl: assert property (!(eccFixed && eccDouble))
    else $error("check code flags both set");
endmodule // assc_props
`default_nettype wire

// file: test/assc_prog_model.sv
// assc_prog_model.sv - external programmer: pin levels and word transfers.
// assumes: tasks are entered on a rising edge of clk and return on one.
`timescale 1ns/10ps
`default_nettype none
module assc_prog_model (
  input wire logic clk,
  input wire logic cfgReady,
  input wire logic cfgRdValid,
  input wire logic cfgWrDone,
  input wire logic [31:0] cfgRdData,
  output logic [5:0] cfgAddr,
  output logic [31:0] cfgWrData,
  output logic cfgWrReq,
  output logic cfgRdReq,
  output logic manchesterModeIn,
  output logic hvPulseIn
);
  // pins idle low until a scenario asks otherwise
  initial begin
    {cfgAddr, cfgWrData} = 38'h0;
    {cfgWrReq, cfgRdReq, manchesterModeIn, hvPulseIn} = 4'h0;
  end
  // the device refuses all while it reloads, so wait with a bound
  task automatic waitReady();
    int n;
    n = 0;
    while (cfgReady !== 1'h1 && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  // pins pass a three-stage synchroniser, so allow four edges
  task automatic mode(input logic m);
    manchesterModeIn <= m;
    repeat (4) @(posedge clk);
  endtask
  // one word read; ok stays low when refused
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic ok);
    waitReady();
    cfgAddr <= a;
    cfgRdReq <= 1'h1;
    @(posedge clk);
    cfgRdReq <= 1'h0;
    cfgAddr <= ~a; // no stale address once released
    repeat (2) @(posedge clk);
    d = cfgRdData;
    ok = cfgRdValid;
  endtask
  // high-voltage level held across the write; reserved low bits of 0x3A and bits 24:13 of 0x3B zeroed
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic hv,
                    output logic ok);
    hvPulseIn <= hv;
    repeat (4) @(posedge clk);
    waitReady();
    if (a == 6'h3A) d[11:0] = 12'h000;
    if (a == 6'h3B) d[24:13] = 12'h000;
    cfgAddr <= a;
    cfgWrData <= d;
    cfgWrReq <= 1'h1;
    @(posedge clk);
    cfgWrReq <= 1'h0;
    cfgAddr <= ~a;
    cfgWrData <= ~d;
    @(posedge clk);
    ok = cfgWrDone;
    hvPulseIn <= 1'h0;
    @(posedge clk);
    waitReady();
  endtask
endmodule // assc_prog_model
`default_nettype wire

// file: test/tb.sv
// tb.sv - self-checking bench for the angle configuration block.
// assumes: design, programmer model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst, angleValid, manchesterModeIn, hvPulseIn, cfgWrReq, cfgRdReq, ok;
  logic angleOutValid, diagMaxOut, diagMinOut, cfgRdValid, cfgWrDone, cfgRefused;
  logic eccFixed, eccDouble, cfgReady, storeWriteLock;
  logic [5:0] cfgAddr;
  logic [11:0] angleIn, angleOut;
  logic [31:0] cfgWrData, cfgRdData, d;
  logic [31:0] cw [4];
  int failCount, compares, cycles, refusals;

  assc_angle_proc assc_angle_proc_inst (.clk, .rst, .angleIn, .angleValid,
    .manchesterModeIn, .hvPulseIn, .cfgAddr, .cfgWrData, .cfgWrReq, .cfgRdReq,
    .angleOut, .angleOutValid, .diagMaxOut, .diagMinOut, .cfgRdData, .cfgRdValid,
    .cfgWrDone, .cfgRefused, .eccFixed, .eccDouble, .cfgReady, .storeWriteLock);
  assc_prog_model assc_prog_model_inst (.clk, .cfgReady, .cfgRdValid, .cfgWrDone,
    .cfgRdData, .cfgAddr, .cfgWrData, .cfgWrReq, .cfgRdReq, .manchesterModeIn,
    .hvPulseIn);

  // 100 ns period
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ceiling far above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      print_verdict();
    end
  end

  // every refused request shows as one cfgRefused pulse
  always @(posedge clk) begin
    if (cfgRefused === 1'h1) refusals <= refusals + 1;
  end

  task automatic print_verdict();
    $display("compares %0d failCount %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected output from the tb's copy of the four words
  function automatic int calc(input int a, output logic dx, output logic dn);
    int c, s, p, hi, lo, po;
    c = (a - int'(cw[0][23:12])) & 4095;
    dx = cw[1][25] && c > cw[2][23:12];
    dn = cw[1][25] && c < cw[2][11:0];
    s = cw[1][25] ? (c * (256 + cw[1][12:0])) >> 8 : c;
    po = cw[3][23:12];
    p = s + (po >= 2048 ? po - 4096 : po);
    hi = 4095 - 45 * cw[3][11:6];
    lo = 45 * cw[3][5:0];
    if (cw[2][25] && !cw[2][24]) return p < 0 ? lo : p > hi ? hi : p < lo ? lo : p;
    p = p & 4095;
    if (cw[2][25]) return p < lo ? lo : p > hi ? hi : p;
    if (cw[2][24]) return hi < lo ? lo : lo + ((p - lo) & 4095) % (hi - lo + 1);
    return p;
  endfunction
  // junk in the reserved low bits of the first word must not stick
  task automatic setCfg(input logic [31:0] w0, w1, w2, w3);
    cw = '{w0, w1, w2, w3};
    for (int i = 0; i < 4; i++) begin
      assc_prog_model_inst.wr(6'h3A + 6'(i), cw[i] | (i == 0 ? 32'hABC : 32'h0), 1'h1, ok);
      chk("write done", 32'h1, {31'h0, ok});
    end
  endtask
  // output may take extra cycles while the wrap mode folds
  task automatic angles(input int t[$]);
    int o, n;
    logic dx, dn;
    foreach (t[i]) begin
      o = calc(t[i], dx, dn);
      assc_prog_model_inst.waitReady();
      angleIn <= 12'(t[i]);
      angleValid <= 1'h1;
      @(posedge clk);
      angleValid <= 1'h0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (angleOutValid !== 1'h1 && n < 600);
      chk("angle", 32'(o), {20'h0, angleOut});
      chk("diag max", {31'h0, dx}, {31'h0, diagMaxOut});
      chk("diag min", {31'h0, dn}, {31'h0, diagMinOut});
    end
  endtask

  initial begin
    rst = 1'h1;
    angleIn = 12'h000;
    angleValid = 1'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    // reads outside the output mode and at an unmapped word are refused
    assc_prog_model_inst.rd(6'h3A, d, ok);
    chk("read no mode", 32'h0, {31'h0, ok});
    assc_prog_model_inst.mode(1'h1);
    assc_prog_model_inst.rd(6'h39, d, ok);
    chk("read unmapped", 32'h0, {31'h0, ok});
    // every word reads back; the four angle words come up cleared
    for (int i = 0; i < 6; i++) begin
      assc_prog_model_inst.rd(6'h3A + 6'(i), d, ok);
      chk("read ok", 32'h1, {31'h0, ok});
      if (i < 4) chk("reset word", 32'h0, d);
    end
    chk("check flags", 32'h0, {30'h0, eccFixed, eccDouble});
    assc_prog_model_inst.wr(6'h3A, 32'h0, 1'h0, ok);
    chk("write no hv", 32'h0, {31'h0, ok});
    // zero adjust only; limits set but short stroke off
    setCfg(32'h0010_0000, 32'h0, 32'h0010_0050, 32'h0);
    assc_prog_model_inst.rd(6'h3A, d, ok);
    chk("zero adjust word", {6'h0, cw[0][25:0]}, {6'h0, d[25:0]});
    angles({80, 0, 4000});
    // gain 1.5 with limits at their edges
    setCfg(32'h0, 32'h0200_0080, 32'h0040_0050, 32'h0);
    angles({64, 80, 512, 1024, 1280, 4095});
    setCfg(32'h0, 32'h0200_0000, 32'h00FF_F000, 32'h0);
    angles({0, 4095});
    // all four clamp and wrap modes, gain two, negative post offset
    for (int k = 0; k < 4; k++) begin
      setCfg(32'h0, 32'h0200_0100, {6'h0, 2'(k), 24'hFFF000}, 32'h00F0_028A);
      angles({16, 256, 1024, 2304});
    end
    // once locked, writes are refused and the word keeps its value
    assc_prog_model_inst.wr(6'h3E, 32'h0200_0000, 1'h1, ok);
    chk("lock write", 32'h1, {31'h0, ok});
    chk("lock level", 32'h1, {31'h0, storeWriteLock});
    assc_prog_model_inst.wr(6'h3A, 32'h0030_0000, 1'h1, ok);
    chk("locked write", 32'h0, {31'h0, ok});
    assc_prog_model_inst.rd(6'h3A, d, ok);
    chk("locked word", {6'h0, cw[0][25:0]}, {6'h0, d[25:0]});
    // two refused reads, the write without high voltage and the locked write
    chk("refusals", 32'h4, 32'(refusals));
    print_verdict();
  end
endmodule // tb

bind assc_angle_proc assc_props assc_props_inst (.clk, .rst, .cfgAddr, .cfgWrReq,
  .cfgRdReq, .angleOut, .angleOutValid, .diagMaxOut, .cfgRdData, .cfgRdValid,
  .cfgWrDone, .cfgRefused, .eccFixed, .eccDouble, .cfgReady, .storeWriteLock);
`default_nettype wire
